//--- design/ccfoc_defines.svh
// Purpose: constants of the forwarding output stage
// Assumes: included by bare name
// Notes: offsets are byte addresses of the 8-bit register map
`ifndef CCFOC_DEFINES_SVH
`define CCFOC_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CF_A_GEN 8'h02
`define CF_A_MAP 8'h20
`define CF_A_MODE 8'h21
`define CF_A_PSEL 8'h32
`define CF_A_CTL 8'h33
`define CF_A_STS 8'h34
// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define CF_GEN_OUT_EN 0
`define CF_GEN_OSS 1
`define CF_MODE_SYNC 5:4
`define CF_SYNC_INTLV 2'h2
`define CF_SYNC_CONCAT 2'h3
`define CF_MODE_REPL 7
`define CF_CTL_EN 0
`define CF_MAP_TX 7:4
`define CF_MAP_DIS 3:0
// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define CF_RST_REG 8'h00
`define CF_RST_PSEL 8'h01
`define CF_CRC_INIT 16'hffff
`define CF_CRC_POLY 16'h8408
`define CF_FIFO_DEPTH 4
`endif

//--- design/ccfoc_pkg.sv
// Purpose: types shared by the forwarding output stage
// Assumes: nothing
// Notes: beats travel as packed structs
package ccfoc_pkg;
    // kind of a beat offered by a receive buffer
    typedef enum logic [1:0] {CF_K_FS = 2'b00, CF_K_FE = 2'b01, CF_K_LS = 2'b10,
        CF_K_DB = 2'b11} ccfoc_kind_e;
    // kind of a beat sent toward the transmitter
    typedef enum logic [2:0] {CF_O_FS = 3'b000, CF_O_FE = 3'b001, CF_O_HDR = 3'b010,
        CF_O_DAT = 3'b011, CF_O_FTR = 3'b100} ccfoc_okind_e;
    // forwarding engine states
    typedef enum logic [2:0] {CF_S_WFS = 3'b000, CF_S_LINE = 3'b001, CF_S_HDR = 3'b010,
        CF_S_DAT = 3'b011, CF_S_FTR = 3'b100} ccfoc_state_e;
    // receive buffer head beat
    typedef struct packed {
        ccfoc_kind_e kind;
        logic last;
        logic [1:0] vc;
        logic [15:0] wc;
        logic [7:0] data;
    } ccfoc_rx_beat_s;
    // transmit beat: wc, data byte or checksum in data
    typedef struct packed {
        ccfoc_okind_e kind;
        logic [1:0] vc;
        logic [15:0] data;
    } ccfoc_tx_beat_s;
endpackage

//--- design/ccfoc_fifo.sv
// Purpose: small valid/ready fifo in the transmit path
// Assumes: D is a power of two
// Notes: full and empty come from pointers with a wrap bit
`timescale 1ns/100ps
`default_nettype none
module ccfoc_fifo #(
    parameter int W = 21,
    parameter int D = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D]; // storage words
    logic [AW:0] wp_q; // write pointer with wrap bit
    logic [AW:0] rp_q; // read pointer with wrap bit
    wire logic push = in_valid && in_ready;
    wire logic pop = out_valid && out_ready;
    assign in_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
    assign out_valid = (wp_q != rp_q);
    assign out_data = mem_q[rp_q[AW-1:0]];
    // pointers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_q + (AW+1)'(push);
            rp_q <= rp_q + (AW+1)'(pop);
        end
    end
    // storage, no reset needed
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem_q[wp_q[AW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

//--- design/ccfoc_top.sv
// Purpose: synchronized line forwarding toward csi transmitter 0, copied to transmitter 1 in replicate mode
// Assumes: receive buffers on core_clk; pins sampled with 3 flops
// Notes: link_clk edges pace the transmit byte stream
`timescale 1ns/100ps
`default_nettype none
`include "ccfoc_defines.svh"
module ccfoc_top
    import ccfoc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    input wire logic [3:0] rx_valid,
    input wire ccfoc_rx_beat_s [3:0] rx_beat,
    output logic [3:0] rx_ready_q,
    input wire logic [3:0] rx_lock,
    input wire logic power_down_pin_n,
    input wire logic link_clk,
    output ccfoc_tx_beat_s tx0_beat_q,
    output logic tx0_vld_q,
    output logic tx0_oe_n_q,
    output logic tx0_hs0_q,
    output ccfoc_tx_beat_s tx1_beat_q,
    output logic tx1_vld_q,
    output logic tx1_oe_n_q,
    output logic tx1_hs0_q
);
    // ----------------------------------------
    // functions
    // ----------------------------------------
    // lowest set port of a mask
    function automatic logic [1:0] cf_first(input logic [3:0] m);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 3; i >= 0; i--)
            if (m[i])
                r = 2'(i);
        return r;
    endfunction
    // next set port above p: {found, index}
    function automatic logic [2:0] cf_next(input logic [3:0] m, input logic [1:0] p);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 3; i >= 0; i--)
            if (m[i] && (2'(i) > p))
                r = {1'b1, 2'(i)};
        return r;
    endfunction
    // checksum over one payload byte
    function automatic logic [15:0] cf_crc(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++)
            r = r[0] ? ((r >> 1) ^ `CF_CRC_POLY) : (r >> 1);
        return r;
    endfunction
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [5:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_st_q; // 3 stages and settled value
    wire logic [5:0] pin_in = {link_clk, power_down_pin_n, rx_lock};
    // a change counts once stages 2 and 3 agree
    wire logic [5:0] pin_st_d = (~(pin_s2_q ^ pin_s3_q) & pin_s3_q)
        | ((pin_s2_q ^ pin_s3_q) & pin_st_q);
    wire logic tick = pin_st_d[5] && !pin_st_q[5]; // link clock rising edge
    wire logic pd_ok = pin_st_q[4]; // power-down released
    wire logic [3:0] lock = pin_st_q[3:0];
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= 6'h00;
            pin_s2_q <= 6'h00;
            pin_s3_q <= 6'h00;
            pin_st_q <= 6'h00;
        end
        else
        begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_st_q <= pin_st_d;
        end
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] gen_q, map_q, mode_q, psel_q, ctl0_q, ctl1_q; // software registers
    logic lost_q; // sticky sync-lost flag
    logic lost_set; // engine saw sync failure
    ccfoc_state_e state_q, state_d;
    wire logic wr_gen = reg_wr && (reg_addr == `CF_A_GEN);
    wire logic wr_map = reg_wr && (reg_addr == `CF_A_MAP);
    wire logic wr_mode = reg_wr && (reg_addr == `CF_A_MODE);
    wire logic wr_psel = reg_wr && (reg_addr == `CF_A_PSEL);
    wire logic wr_ctl = reg_wr && (reg_addr == `CF_A_CTL);
    wire logic rd_sts = reg_rd && (reg_addr == `CF_A_STS);
    // lock seen on ports mapped to each transmitter
    wire logic lk0 = |(lock & ~map_q[`CF_MAP_TX]);
    wire logic lk1 = |(lock & map_q[`CF_MAP_TX]);
    logic [7:0] rd_d; // read mux
    always_comb
    begin
        if (reg_addr == `CF_A_GEN)
            rd_d = gen_q;
        else if (reg_addr == `CF_A_MAP)
            rd_d = map_q;
        else if (reg_addr == `CF_A_MODE)
            rd_d = mode_q;
        else if (reg_addr == `CF_A_PSEL)
            rd_d = psel_q;
        else if (reg_addr == `CF_A_CTL)
            rd_d = psel_q[0] ? ctl0_q : ctl1_q;
        else if (reg_addr == `CF_A_STS)
            rd_d = {4'h0, lk1, lk0, lost_q, (state_q != CF_S_WFS)};
        else
            rd_d = 8'h00; // unmapped reads zero
    end
    // register writes; ctl goes to the selected transmitter
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            gen_q <= `CF_RST_REG;
            map_q <= `CF_RST_REG;
            mode_q <= `CF_RST_REG;
            psel_q <= `CF_RST_PSEL;
            ctl0_q <= `CF_RST_REG;
            ctl1_q <= `CF_RST_REG;
            lost_q <= 1'b0;
            reg_rdata_q <= 8'h00;
        end
        else
        begin
            if (wr_gen) gen_q <= reg_wdata;
            if (wr_map) map_q <= reg_wdata;
            if (wr_mode) mode_q <= reg_wdata;
            if (wr_psel) psel_q <= reg_wdata;
            if (wr_ctl && psel_q[0]) ctl0_q <= reg_wdata;
            if (wr_ctl && psel_q[1]) ctl1_q <= reg_wdata;
            lost_q <= lost_set || (lost_q && !rd_sts); // set wins over read clear
            reg_rdata_q <= reg_rd ? rd_d : 8'h00;
        end
    end
    // ----------------------------------------
    // forwarding engine
    // ----------------------------------------
    wire logic [1:0] sync = mode_q[`CF_MODE_SYNC];
    wire logic concat = (sync == `CF_SYNC_CONCAT);
    wire logic run = ctl0_q[`CF_CTL_EN] && (concat || (sync == `CF_SYNC_INTLV));
    // enabled ports mapped to tx0
    wire logic [3:0] act = run ? (~map_q[`CF_MAP_DIS] & ~map_q[`CF_MAP_TX]) : 4'h0;
    wire logic [1:0] low = cf_first(act);
    wire logic go = (rx_ready_q == 4'h0); // wait while a take is in flight
    logic [3:0] is_fs, is_fe, is_ls; // head kinds per port
    logic [15:0] wc_sum; // combined line byte count
    always_comb
    begin
        wc_sum = 16'h0000;
        for (int i = 0; i < 4; i++)
        begin
            is_fs[i] = rx_valid[i] && (rx_beat[i].kind == CF_K_FS);
            is_fe[i] = rx_valid[i] && (rx_beat[i].kind == CF_K_FE);
            is_ls[i] = rx_valid[i] && (rx_beat[i].kind == CF_K_LS);
            if (act[i])
                wc_sum = 16'(wc_sum + rx_beat[i].wc);
        end
    end
    wire logic any_act = (act != 4'h0);
    wire logic all_fs = any_act && (&(~act | is_fs));
    wire logic all_fe = any_act && (&(~act | is_fe));
    wire logic all_ls = any_act && (&(~act | is_ls));
    wire logic all_vld = any_act && (&(~act | rx_valid));
    logic [1:0] p_q, p_d; // port being forwarded
    logic [1:0] vc_q, vc_d; // frame virtual channel
    logic [15:0] crc_q, crc_d; // running line checksum
    logic [3:0] pop_d; // heads taken this step
    logic out_vld; // beat offered to fifo
    ccfoc_tx_beat_s out_beat;
    logic f_in_rdy; // fifo has room
    wire logic push = out_vld && f_in_rdy;
    wire ccfoc_rx_beat_s hd = rx_beat[p_q];
    wire logic hv = rx_valid[p_q];
    wire logic [2:0] nx = cf_next(act, p_q);
    // engine next state
    always_comb
    begin
        state_d = state_q;
        p_d = p_q;
        vc_d = vc_q;
        crc_d = crc_q;
        pop_d = 4'h0;
        out_vld = 1'b0;
        out_beat = '{kind: CF_O_FS, vc: vc_q, data: 16'h0000};
        lost_set = 1'b0;
        if (go && any_act)
        begin
            case (state_q)
                CF_S_WFS:
                begin
                    // drop non-FS heads until all active ports show FS
                    pop_d = act & rx_valid & ~is_fs;
                    if (all_fs)
                    begin
                        out_vld = 1'b1;
                        out_beat.vc = rx_beat[low].vc;
                        if (push)
                        begin
                            pop_d = act; // one FS kept, rest dropped
                            vc_d = rx_beat[low].vc;
                            state_d = CF_S_LINE;
                        end
                    end
                end
                CF_S_LINE:
                begin
                    if (all_ls)
                    begin
                        p_d = low; // start at lowest port
                        state_d = CF_S_HDR;
                    end
                    else if (all_fe)
                    begin
                        out_vld = 1'b1;
                        out_beat.kind = CF_O_FE;
                        if (push)
                        begin
                            pop_d = act; // one FE only
                            state_d = CF_S_WFS;
                        end
                    end
                    else if (all_vld)
                    begin
                        lost_set = 1'b1; // ports out of step
                        state_d = CF_S_WFS;
                    end
                end
                CF_S_HDR:
                begin
                    out_vld = 1'b1;
                    out_beat.kind = CF_O_HDR;
                    out_beat.data = concat ? wc_sum : hd.wc;
                    if (push)
                    begin
                        pop_d = concat ? act : (4'h1 << p_q);
                        crc_d = `CF_CRC_INIT;
                        state_d = CF_S_DAT;
                    end
                end
                CF_S_DAT:
                begin
                    if (hv && (hd.kind == CF_K_DB))
                    begin
                        out_vld = 1'b1;
                        out_beat.kind = CF_O_DAT;
                        out_beat.data = {8'h00, hd.data};
                        if (push)
                        begin
                            pop_d = 4'h1 << p_q;
                            crc_d = cf_crc(crc_q, hd.data);
                            if (hd.last && concat && nx[2])
                                p_d = nx[1:0]; // next camera, no filler
                            else if (hd.last)
                                state_d = CF_S_FTR;
                        end
                    end
                    else if (hv)
                    begin
                        lost_set = 1'b1; // line cut short
                        state_d = CF_S_WFS;
                    end
                end
                CF_S_FTR:
                begin
                    out_vld = 1'b1;
                    out_beat.kind = CF_O_FTR;
                    out_beat.data = crc_q;
                    if (push && !concat && nx[2])
                    begin
                        p_d = nx[1:0]; // next camera's own packet
                        state_d = CF_S_HDR;
                    end
                    else if (push)
                        state_d = CF_S_LINE;
                end
                default:
                    state_d = CF_S_WFS;
            endcase
        end
        else if (!any_act)
            state_d = CF_S_WFS;
    end
    // engine registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_q <= CF_S_WFS;
            p_q <= 2'h0;
            vc_q <= 2'h0;
            crc_q <= `CF_CRC_INIT;
            rx_ready_q <= 4'h0;
        end
        else
        begin
            state_q <= state_d;
            p_q <= p_d;
            vc_q <= vc_d;
            crc_q <= crc_d;
            rx_ready_q <= pop_d;
        end
    end
    // ----------------------------------------
    // fifo and pin stage
    // ----------------------------------------
    logic f_out_vld; // beat waiting for the link
    ccfoc_tx_beat_s f_out;
    ccfoc_fifo #(.W($bits(ccfoc_tx_beat_s)), .D(`CF_FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(out_vld),
        .in_ready(f_in_rdy),
        .in_data(out_beat),
        .out_valid(f_out_vld),
        .out_ready(tick),
        .out_data(f_out)
    );
    wire logic sleep_state_select = gen_q[`CF_GEN_OSS];
    wire logic csi_output_enable_bit = gen_q[`CF_GEN_OUT_EN];
    wire logic repl = mode_q[`CF_MODE_REPL];
    wire logic hs0 = pd_ok && !sleep_state_select;
    // pins parked hi-z by the enable bit alone
    wire logic en_off = pd_ok && sleep_state_select && !csi_output_enable_bit;
    // normal operation, activity still to be seen
    wire logic drive_ok = pd_ok && sleep_state_select && csi_output_enable_bit;
    wire logic ok0 = drive_ok && lk0 && ctl0_q[`CF_CTL_EN];
    wire logic ok1 = drive_ok && lk1 && ctl1_q[`CF_CTL_EN];
    wire logic oe0_n = !(hs0 || ok0);
    wire logic oe1_n = !(hs0 || ok1);
    wire logic vld0_d = tick ? (f_out_vld && ok0) : (tx0_vld_q && ok0);
    wire ccfoc_tx_beat_s beat0_d = (tick && f_out_vld) ? f_out : tx0_beat_q;
    // one fifo word per link clock rising edge
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            tx0_beat_q <= '0;
            tx0_vld_q <= 1'b0;
            tx0_oe_n_q <= 1'b1;
            tx0_hs0_q <= 1'b0;
            tx1_beat_q <= '0;
            tx1_vld_q <= 1'b0;
            tx1_oe_n_q <= 1'b1;
            tx1_hs0_q <= 1'b0;
        end
        else
        begin
            tx0_beat_q <= beat0_d;
            tx0_vld_q <= vld0_d;
            tx0_oe_n_q <= oe0_n;
            tx0_hs0_q <= hs0;
            tx1_beat_q <= repl ? beat0_d : '0;
            tx1_vld_q <= repl && vld0_d;
            tx1_oe_n_q <= repl ? oe0_n : oe1_n;
            tx1_hs0_q <= hs0;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] cnt_q, hwc_q; // bytes since header, header count
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || (push && out_beat.kind == CF_O_HDR))
            cnt_q <= 16'h0000;
        else if (push && out_beat.kind == CF_O_DAT)
            cnt_q <= 16'(cnt_q + 16'h0001);
        if (!rst_n)
            hwc_q <= 16'h0000;
        else if (push && out_beat.kind == CF_O_HDR)
            hwc_q <= out_beat.data;
    end
    a_line_count_sum: assert property (push && out_beat.kind == CF_O_FTR |-> cnt_q == hwc_q)
        else $error("footer byte count differs from header");
    a_fe_one_frame: assert property (push && out_beat.kind == CF_O_FE |=> state_q == CF_S_WFS)
        else $error("frame end did not close frame");
    a_fs_single: assert property (push && out_beat.kind == CF_O_FS |=> rx_ready_q == act)
        else $error("other frame starts not dropped");
    a_vc_lowest: assert property (push && out_beat.kind != CF_O_FS |-> out_beat.vc == vc_q)
        else $error("packet vc differs from frame vc");
    a_pd_hiz: assert property (!pd_ok |=> tx0_oe_n_q && tx1_oe_n_q && !tx0_vld_q)
        else $error("pins driven in power-down");
    a_hs0_force: assert property (hs0 |=> tx0_hs0_q && !tx0_oe_n_q && !tx0_vld_q)
        else $error("hs-0 not forced");
    a_outen_hiz: assert property (en_off |=> tx0_oe_n_q && tx1_oe_n_q)
        else $error("pins driven with output disabled");
    a_repl_copy: assert property (repl |=> tx1_beat_q == tx0_beat_q && tx1_vld_q == tx0_vld_q)
        else $error("tx1 differs from tx0 in replicate");
    wire logic stray_wfs = go && (state_q == CF_S_WFS) && |(act & rx_valid & ~is_fs); // head to drop
    a_wfs_discard: assert property (stray_wfs |=> |rx_ready_q)
        else $error("packet not discarded while unsynced");
    c_concat_line: cover property (push && concat && out_beat.kind == CF_O_FTR);
    c_intlv_line: cover property (push && !concat && out_beat.kind == CF_O_FTR);
    c_sync_lost: cover property (lost_set);
    c_frame_end: cover property (push && out_beat.kind == CF_O_FE);
endmodule
`default_nettype wire

//--- sim/ccfoc_rx_model.sv
// Purpose: downstream csi receiver model; makes the link clock, captures words
// Assumes: words settle well before link_clk falls
// Notes: link clock stands low while run is low
`timescale 1ns/100ps
`default_nettype none
module ccfoc_rx_model
    import ccfoc_pkg::*;
(
    input wire logic run,
    output logic link_clk,
    input wire ccfoc_tx_beat_s beat,
    input wire logic vld
);
    ccfoc_tx_beat_s got[$]; // words seen, in order, for splitting by position
    // 160 ns byte clock, only within traffic
    initial
    begin
        link_clk = 1'b0;
        forever
        begin
            #80 link_clk = run & ~link_clk;
        end
    end
    // one word per period, taken mid-period while pins are valid
    always @(negedge link_clk)
    begin
        if (vld === 1'b1)
        begin
            got.push_back(beat);
        end
    end
endmodule
`default_nettype wire

//--- sim/csi2_concat_forward_output_ctl_bench.sv
// Purpose: self-checking bench of the forwarding output stage
// Assumes: ports 0 and 1 carry video, ports 2 and 3 disabled
// Notes: frames queue before the link runs, so the fifo fills first
`timescale 1ns/100ps
`default_nettype none
`include "ccfoc_defines.svh"
module csi2_concat_forward_output_ctl_bench
    import ccfoc_pkg::*;
;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic core_clk, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
    logic power_down_pin_n = 1'b1, link_clk;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
    logic [3:0] rx_valid = 4'h0, rx_ready_q, rx_lock = 4'hf;
    ccfoc_rx_beat_s [3:0] rx_beat = '0;
    ccfoc_tx_beat_s tx0_beat_q, tx1_beat_q;
    logic tx0_vld_q, tx0_oe_n_q, tx0_hs0_q, tx1_vld_q, tx1_oe_n_q, tx1_hs0_q;
    int n_mismatch = 0, n_checks = 0;
    ccfoc_rx_beat_s feed[4][$]; // beats waiting per port
    ccfoc_tx_beat_s exp_q[$]; // expected words on tx0
    ccfoc_top i_dut (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata_q, .rx_valid, .rx_beat, .rx_ready_q, .rx_lock, .power_down_pin_n,
        .link_clk, .tx0_beat_q, .tx0_vld_q, .tx0_oe_n_q, .tx0_hs0_q, .tx1_beat_q,
        .tx1_vld_q, .tx1_oe_n_q, .tx1_hs0_q);
    ccfoc_rx_model m0 (.run, .link_clk, .beat(tx0_beat_q), .vld(tx0_vld_q));
    ccfoc_rx_model m1 (.run, .link_clk(), .beat(tx1_beat_q), .vld(tx1_vld_q));
    // 4 ns core clock
    initial
    begin
        core_clk = 1'b0;
        forever
            #2 core_clk = ~core_clk;
    end
    // present queued beats, advance on the take pulse
    always @(posedge core_clk)
    begin
        for (int p = 0; p < 4; p++)
        begin
            if (rx_ready_q[p] === 1'b1 && feed[p].size() > 0)
                void'(feed[p].pop_front());
            rx_valid[p] <= feed[p].size() > 0;
            rx_beat[p] <= feed[p].size() > 0 ? feed[p][0] : '0;
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic ccfoc_rx_beat_s rb(ccfoc_kind_e k, logic l, logic [15:0] w,
        logic [7:0] d, logic [1:0] v);
        return '{k, l, v, w, d};
    endfunction
    function automatic ccfoc_tx_beat_s tb(ccfoc_okind_e k, logic [15:0] d);
        return '{k, 2'h1, d};
    endfunction
    task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", 21'(e), 21'(reg_rdata_q));
        @(posedge core_clk);
    endtask
    // pin state after gating inputs settle through the synchronisers
    task automatic pins(input logic pd_n, input logic [7:0] gen, input logic [3:0] lk,
        input logic [1:0] e);
        power_down_pin_n <= pd_n;
        rx_lock <= lk;
        wr(`CF_A_GEN, gen);
        repeat (8) @(posedge core_clk);
        chk("oe_n hs0", 21'(e), 21'({tx0_oe_n_q, tx0_hs0_q}));
        // tx1 is never enabled here, so it can only be hs-0 or hi-z
        chk("tx1 oe_n hs0", 21'(e == 2'b00 ? 2'b10 : e), 21'({tx1_oe_n_q, tx1_hs0_q}));
    endtask
    // ports disagree after frame start: line start on 0, frame end on 1
    task automatic lose_sync();
        for (int p = 0; p < 2; p++)
        begin
            feed[p].push_back(rb(CF_K_FS, 1'b0, 16'h0, 8'h0, 2'h1));
            feed[p].push_back(rb(p ? CF_K_FE : CF_K_LS, 1'b0, 16'h2, 8'h0, 2'h1));
        end
        run <= 1'b1;
        repeat (100) @(posedge core_clk);
        run <= 1'b0;
        repeat (60) @(posedge core_clk);
        chk("lost count", 21'h1, 21'(m0.got.size()));
        chk("lost word", tb(CF_O_FS, 16'h0000), m0.got[0]);
        rd(`CF_A_STS, 8'h06);
        rd(`CF_A_STS, 8'h04);
        m0.got = {};
        $display("done sync loss");
    endtask
    // ----------------------------------------
    // one two-line frame from ports 0 and 1
    // ----------------------------------------
    task automatic frame(input logic [7:0] mode);
        logic [15:0] crc;
        logic [7:0] d;
        logic cat;
        int n;
        cat = mode[5:4] == 2'h3;
        wr(`CF_A_MODE, mode);
        exp_q = '{tb(CF_O_FS, 16'h0000)};
        for (int p = 0; p < 2; p++)
        begin
            feed[p].push_back(rb(CF_K_FS, 1'b0, 16'h0, 8'h0, 2'(p + 1)));
            for (int l = 0; l < 2; l++)
            begin
                feed[p].push_back(rb(CF_K_LS, 1'b0, 16'(p + 2), 8'h0, 2'(p + 1)));
                for (int i = 0; i < p + 2; i++)
                    feed[p].push_back(rb(CF_K_DB, i == p + 1, 16'h0, 8'(16 * l + 4 * p + i),
                        2'(p + 1)));
            end
            feed[p].push_back(rb(CF_K_FE, 1'b0, 16'h0, 8'h0, 2'(p + 1)));
        end
        for (int l = 0; l < 2; l++)
            for (int p = 0; p < 2; p++)
            begin
                if (p == 0 || !cat)
                begin
                    crc = 16'hffff;
                    exp_q.push_back(tb(CF_O_HDR, cat ? 16'h0005 : 16'(p + 2)));
                end
                for (int i = 0; i < p + 2; i++)
                begin
                    d = 8'(16 * l + 4 * p + i);
                    exp_q.push_back(tb(CF_O_DAT, {8'h00, d}));
                    crc = crc ^ {8'h00, d};
                    repeat (8) crc = crc[0] ? (crc >> 1) ^ 16'h8408 : crc >> 1;
                end
                if (p == 1 || !cat)
                    exp_q.push_back(tb(CF_O_FTR, crc));
            end
        exp_q.push_back(tb(CF_O_FE, 16'h0000));
        repeat (200) @(posedge core_clk);
        run <= 1'b1;
        for (n = 0; n < 3000 && m0.got.size() < exp_q.size(); n++)
            @(posedge core_clk);
        run <= 1'b0;
        repeat (60) @(posedge core_clk);
        if (n == 3000)
            n_mismatch++; // link stalled; counted, run goes on to the report
        chk("count", 21'(exp_q.size()), 21'(m0.got.size()));
        foreach (exp_q[k])
            chk("word", exp_q[k], m0.got[k]);
        chk("tx1 count", mode[7] ? 21'(exp_q.size()) : 21'h0, 21'(m1.got.size()));
        foreach (m1.got[k])
            chk("tx1 word", exp_q[k], m1.got[k]);
        m0.got = {};
        m1.got = {};
        $display("done frame %h", mode);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(`CF_A_PSEL, 8'h01);
        wr(`CF_A_MODE, 8'h3c);
        rd(`CF_A_MODE, 8'h3c);
        rd(8'h55, 8'h00);
        wr(`CF_A_PSEL, 8'h01);
        wr(`CF_A_CTL, 8'h01);
        wr(`CF_A_MAP, 8'h8c);
        pins(1'b1, 8'h03, 4'h8, 2'b10);
        wr(`CF_A_MAP, 8'h0c);
        pins(1'b0, 8'h03, 4'hf, 2'b10);
        pins(1'b1, 8'h00, 4'hf, 2'b01);
        pins(1'b1, 8'h01, 4'h0, 2'b01);
        pins(1'b1, 8'h02, 4'hf, 2'b10);
        pins(1'b1, 8'h03, 4'h0, 2'b10);
        pins(1'b1, 8'h03, 4'h1, 2'b00);
        $display("done pins");
        lose_sync();
        frame(8'h3c);
        frame(8'h28);
        frame(8'hbc);
        final_report();
    end
endmodule
`default_nettype wire
